// file: hw/pmw_core.sv
// PCI core end: master burst write path with local master handshake
`timescale 1ns/1ps

// Overview of operation
// - Request and grant seen: load address phase
// - Local master drops request after address loading
// - Assert frame with address and command next
// - Address phase loads remaining beats with length
// - Ready last cycle: word taken, strobe asserted
// - Local master signals ready only with data
// - Release bus request after frame without request
// - Local master steps address after each strobe
// - Hold early word until pending phase completes
// - Local grant follows the bus grant
// - Phase completes on both readies; hold meanwhile
// - Decrement remaining beats after each completion
// - Target asserts select and ready after decode
// - No word yet: deassert initiator ready
// - Last phase: ready asserted, frame released
// - Last completion: termination phase, normal cause
module pmw_core (
	input  wire logic I_CLK_SYS,
	input  wire logic I_RST_N,
	pmw_if.core       bus,
	output logic      O_DONE
);
	import pmw_pkg::*;

	localparam int HW = AD_W + CBE_W;

	// ****************************************************
	// State
	// ****************************************************
	pmw_phase_t        phase;
	pmw_phase_t        next_phase;
	pmw_cause_t        cause;
	pmw_cause_t        next_cause;
	logic              req_act;
	logic              next_req_act;
	logic              gnt_loc;
	logic              next_gnt_loc;
	logic              req_q;
	logic              next_req_q;
	logic              gnt_q;
	logic              next_gnt_q;
	logic [AD_W-1:0]   addr;
	logic [AD_W-1:0]   next_addr;
	logic [CBE_W-1:0]  cmd;
	logic [CBE_W-1:0]  next_cmd;
	logic [LEN_W-1:0]  len;
	logic [LEN_W-1:0]  next_len;
	logic              frame_act;
	logic              next_frame_act;
	logic              frame_oe;
	logic              next_frame_oe;
	logic              irdy_oe;
	logic              next_irdy_oe;
	logic [AD_W-1:0]   bus_ad;
	logic [AD_W-1:0]   next_bus_ad;
	logic [CBE_W-1:0]  bus_cbe;
	logic [CBE_W-1:0]  next_bus_cbe;
	logic              cur_valid;
	logic              next_cur_valid;
	logic [CNT_W-1:0]  remaining;
	logic [CNT_W-1:0]  next_remaining;
	logic [CNT_W-1:0]  accepted;
	logic [CNT_W-1:0]  next_accepted;
	logic [CNT_W-1:0]  loaded;
	logic [CNT_W-1:0]  next_loaded;
	logic              strobe;
	logic              next_strobe;

	// ****************************************************
	// Holding buffer
	// ****************************************************
	logic              done;
	logic              push;
	logic              pop;
	logic              hold_valid;
	logic [HW-1:0]     hold_data;
	logic [HW-1:0]     in_data;
	logic [1:0]        occ;
	logic [CNT_W-1:0]  len_ext;

	assign in_data = {bus.local_byte_lanes, bus.local_write_word};
	assign len_ext = {1'b0, len};

	pmw_hold_buf #(
		.W (HW)
	) pmw_hold_buf_inst (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.i_push  (push),
		.i_pop   (pop),
		.i_data  (in_data),
		.o_valid (hold_valid),
		.o_data  (hold_data)
	);

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		next_phase      = phase;
		next_cause      = cause;
		next_addr       = addr;
		next_cmd        = cmd;
		next_len        = len;
		next_frame_act  = frame_act;
		next_frame_oe   = frame_oe;
		next_irdy_oe    = irdy_oe;
		next_bus_ad     = bus_ad;
		next_bus_cbe    = bus_cbe;
		next_cur_valid  = cur_valid;
		next_remaining  = remaining;
		next_accepted   = accepted + {{(CNT_W-1){1'b0}}, strobe};
		next_loaded     = loaded;
		push            = 1'b0;
		pop             = 1'b0;
		next_req_q      = bus.local_req_32;
		next_gnt_q      = !bus.gnt_n;
		// Completion needs both readies on the wire
		done = (phase == PH_BUS_TXN) && cur_valid && !bus.irdy_n &&
			!bus.trdy_n;

		if (req_act) begin
			next_req_act = !(!bus.frame_n && !bus.local_req_32);
		end else begin
			next_req_act = bus.local_req_32 && (phase == PH_IDLE);
		end
		// Grant passes down only once the bus is idle
		next_gnt_loc = !bus.gnt_n && (gnt_loc || ((phase == PH_IDLE) &&
			bus.frame_n && bus.irdy_n));

		unique case (phase)
			PH_IDLE: begin
				if (req_q && gnt_q) begin
					next_phase = PH_ADDR_LOAD;
					next_cause = END_NONE;
					next_addr  = bus.local_write_word;
					next_cmd   = bus.local_byte_lanes;
					next_len   = bus.burst_len_in;
				end
			end
			PH_ADDR_LOAD: begin
				// Without grant the loaded request just waits
				if (!bus.gnt_n) begin
					next_phase     = PH_BUS_TXN;
					next_frame_act = 1'b1;
					next_frame_oe  = 1'b1;
					next_irdy_oe   = 1'b1;
					next_bus_ad    = addr;
					next_bus_cbe   = cmd;
					next_cur_valid = 1'b0;
					next_remaining = len_ext;
					next_accepted  = CNT_RST;
					next_loaded    = CNT_RST;
				end
			end
			PH_BUS_TXN: begin
				if (!cur_valid || done) begin
					if (done) begin
						next_remaining = remaining - CNT_ONE;
					end
					if (done && !frame_act) begin
						next_phase      = PH_BUS_TERM;
						next_cause      = END_NORMAL;
						next_frame_oe   = 1'b0;
						next_cur_valid  = 1'b0;
					end else if (hold_valid || strobe) begin
						next_cur_valid = 1'b1;
						next_loaded    = loaded + CNT_ONE;
						if (hold_valid) begin
							pop          = 1'b1;
							push         = strobe;
							next_bus_ad  = hold_data[AD_W-1:0];
							next_bus_cbe = hold_data[HW-1:AD_W];
						end else begin
							next_bus_ad  = bus.local_write_word;
							next_bus_cbe = bus.local_byte_lanes;
						end
						if (next_loaded == len_ext) begin
							next_frame_act = 1'b0;
						end
					end else begin
						next_cur_valid = 1'b0;
					end
				end else if (strobe) begin
					push = 1'b1;
				end
			end
			PH_BUS_TERM: begin
				next_irdy_oe = 1'b0;
				next_phase   = PH_IDLE;
			end
		endcase

		// Credit check keeps the one-word buffer from overflowing
		occ = {1'b0, next_cur_valid} + {1'b0, hold_valid} +
			{1'b0, push} - {1'b0, pop};
		next_strobe = bus.local_master_ready &&
			(next_phase == PH_BUS_TXN) && (occ < OCC_FULL) &&
			(next_accepted < len_ext);
	end

	// ****************************************************
	// Registers
	// ****************************************************
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			phase      <= PH_IDLE;
			cause      <= END_NONE;
			req_act    <= 1'b0;
			gnt_loc    <= 1'b0;
			req_q      <= 1'b0;
			gnt_q      <= 1'b0;
			addr       <= AD_RST;
			cmd        <= CBE_RST;
			len        <= LEN_RST;
			frame_act  <= 1'b0;
			frame_oe   <= 1'b0;
			irdy_oe    <= 1'b0;
			bus_ad     <= AD_RST;
			bus_cbe    <= CBE_RST;
			cur_valid  <= 1'b0;
			remaining  <= CNT_RST;
			accepted   <= CNT_RST;
			loaded     <= CNT_RST;
			strobe     <= 1'b0;
		end else begin
			phase      <= next_phase;
			cause      <= next_cause;
			req_act    <= next_req_act;
			gnt_loc    <= next_gnt_loc;
			req_q      <= next_req_q;
			gnt_q      <= next_gnt_q;
			addr       <= next_addr;
			cmd        <= next_cmd;
			len        <= next_len;
			frame_act  <= next_frame_act;
			frame_oe   <= next_frame_oe;
			irdy_oe    <= next_irdy_oe;
			bus_ad     <= next_bus_ad;
			bus_cbe    <= next_bus_cbe;
			cur_valid  <= next_cur_valid;
			remaining  <= next_remaining;
			accepted   <= next_accepted;
			loaded     <= next_loaded;
			strobe     <= next_strobe;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign bus.req_n              = !req_act;
	assign bus.frame_n_o          = !frame_act;
	assign bus.frame_oe           = frame_oe;
	assign bus.irdy_n_o           = !cur_valid;
	assign bus.irdy_oe            = irdy_oe;
	assign bus.ad_o               = bus_ad;
	assign bus.ad_oe              = frame_oe;
	assign bus.cbe_n_o            = bus_cbe;
	assign bus.cbe_oe             = frame_oe;
	assign bus.local_grant        = gnt_loc;
	assign bus.local_master_phase = phase;
	assign bus.end_cause          = cause;
	assign bus.remaining_beats    = remaining;
	assign bus.local_beat_strobe  = strobe;
	assign O_DONE                 = (phase == PH_BUS_TERM);
endmodule

// file: shared/pmw_pkg.sv
// Shared constants and types for the burst write path
package pmw_pkg;

	// ****************************************************
	// Widths
	// ****************************************************
	localparam int AD_W  = 32;
	localparam int CBE_W = 4;
	localparam int LEN_W = 12;
	localparam int CNT_W = 13;

	// ****************************************************
	// Reset values and steps
	// ****************************************************
	localparam logic [AD_W-1:0]  AD_RST    = 32'h0000_0000;
	localparam logic [CBE_W-1:0] CBE_RST   = 4'h0;
	localparam logic [LEN_W-1:0] LEN_RST   = 12'h000;
	localparam logic [CNT_W-1:0] CNT_RST   = 13'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE   = 13'h0001;
	localparam logic [AD_W-1:0]  ADDR_STEP = 32'h0000_0004;
	localparam logic [1:0]       OCC_FULL  = 2'h2;

	// ****************************************************
	// Local phase and end cause codes
	// ****************************************************
	typedef enum logic [3:0] {
		PH_IDLE      = 4'b0000,
		PH_ADDR_LOAD = 4'b0001,
		PH_BUS_TXN   = 4'b0010,
		PH_BUS_TERM  = 4'b0011
	} pmw_phase_t;

	typedef enum logic [2:0] {
		END_NONE   = 3'b000,
		END_NORMAL = 3'b001
	} pmw_cause_t;

endpackage

// file: shared/pmw_if.sv
// Interface joining the PCI core end and its partner end
`timescale 1ns/1ps
interface pmw_if;
	import pmw_pkg::*;

	// PCI side, active low strobes
	logic              req_n;
	logic              gnt_n;
	logic              frame_n_o;
	logic              frame_oe;
	logic              irdy_n_o;
	logic              irdy_oe;
	logic [AD_W-1:0]   ad_o;
	logic              ad_oe;
	logic [CBE_W-1:0]  cbe_n_o;
	logic              cbe_oe;
	logic              devsel_n_o;
	logic              devsel_oe;
	logic              trdy_n_o;
	logic              trdy_oe;
	logic              frame_n;
	logic              irdy_n;
	logic              devsel_n;
	logic              trdy_n;
	logic [AD_W-1:0]   ad;
	logic [CBE_W-1:0]  cbe_n;

	// Local master side
	logic              local_req_32;
	logic              local_grant;
	pmw_phase_t        local_master_phase;
	pmw_cause_t        end_cause;
	logic [CNT_W-1:0]  remaining_beats;
	logic [LEN_W-1:0]  burst_len_in;
	logic [AD_W-1:0]   local_write_word;
	logic [CBE_W-1:0]  local_byte_lanes;
	logic              local_master_ready;
	logic              local_beat_strobe;

	// Released strobes float high through the bus pull-ups; released ad and cbe_n read as zero
	assign frame_n  = frame_oe  ? frame_n_o  : 1'b1;
	assign irdy_n   = irdy_oe   ? irdy_n_o   : 1'b1;
	assign devsel_n = devsel_oe ? devsel_n_o : 1'b1;
	assign trdy_n   = trdy_oe   ? trdy_n_o   : 1'b1;
	assign ad       = ad_oe     ? ad_o       : AD_RST;
	assign cbe_n    = cbe_oe    ? cbe_n_o    : CBE_RST;

	modport core (
		output req_n, frame_n_o, frame_oe, irdy_n_o, irdy_oe,
		output ad_o, ad_oe, cbe_n_o, cbe_oe,
		output local_grant, local_master_phase, end_cause,
		output remaining_beats, local_beat_strobe,
		input  gnt_n, frame_n, irdy_n, trdy_n, devsel_n,
		input  local_req_32, burst_len_in, local_write_word,
		input  local_byte_lanes, local_master_ready
	);

	modport partner (
		output gnt_n, devsel_n_o, devsel_oe, trdy_n_o, trdy_oe,
		output local_req_32, burst_len_in, local_write_word,
		output local_byte_lanes, local_master_ready,
		input  req_n, frame_n, irdy_n, trdy_n, ad, cbe_n,
		input  local_grant, local_master_phase, end_cause,
		input  remaining_beats, local_beat_strobe
	);
endinterface

// file: hw/pmw_hold_buf.sv
// One-word holding register for a beat that waits on the bus
`timescale 1ns/1ps
module pmw_hold_buf #(
	parameter int W = 36
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_push,
	input  wire logic         i_pop,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	output logic [W-1:0]      o_data
);
	import pmw_pkg::*;

	logic         next_valid;
	logic [W-1:0] next_data;

	// Pop and push in one cycle replace the word
	always_comb begin
		next_valid = o_valid;
		next_data  = o_data;
		if (i_pop) begin
			next_valid = 1'b0;
		end
		if (i_push) begin
			next_valid = 1'b1;
			next_data  = i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
			o_data  <= '0;
		end else begin
			o_valid <= next_valid;
			o_data  <= next_data;
		end
	end
endmodule

// file: hw/pmw_partner.sv
// Partner end: local master, simple arbiter and fast-decode target
`timescale 1ns/1ps
module pmw_partner (
	input  wire logic                  I_CLK_SYS,
	input  wire logic                  I_RST_N,
	pmw_if.partner                     bus,
	input  wire logic                  I_START,
	input  wire logic [pmw_pkg::AD_W-1:0]  I_ADDR,
	input  wire logic [pmw_pkg::CBE_W-1:0] I_CMD,
	input  wire logic [pmw_pkg::LEN_W-1:0] I_LEN,
	input  wire logic [pmw_pkg::AD_W-1:0]  I_WORD,
	input  wire logic [pmw_pkg::CBE_W-1:0] I_LANES,
	input  wire logic                  I_WORD_VALID,
	input  wire logic                  I_TGT_STALL,
	output logic [pmw_pkg::CNT_W-1:0]  O_NEXT_INDEX,
	output logic [pmw_pkg::AD_W-1:0]   O_ADDR_COUNT,
	output logic                       O_BUSY,
	output logic [pmw_pkg::AD_W-1:0]   O_TGT_WORD,
	output logic [pmw_pkg::CBE_W-1:0]  O_TGT_LANES,
	output logic                       O_TGT_VALID
);
	import pmw_pkg::*;

	// ****************************************************
	// State
	// ****************************************************
	logic              req;
	logic              next_req;
	logic              busy;
	logic              next_busy;
	logic              ready;
	logic              next_ready;
	logic [AD_W-1:0]   word;
	logic [AD_W-1:0]   next_word;
	logic [CBE_W-1:0]  lanes;
	logic [CBE_W-1:0]  next_lanes;
	logic [LEN_W-1:0]  len;
	logic [LEN_W-1:0]  next_len;
	logic [AD_W-1:0]   count;
	logic [AD_W-1:0]   next_count;
	logic [CNT_W-1:0]  beats;
	logic [CNT_W-1:0]  next_beats;
	logic              gnt;
	logic              next_gnt;
	logic              frame_q;
	logic              sel;
	logic              next_sel;
	logic              tgt_done;
	logic [AD_W-1:0]   tgt_word;
	logic [CBE_W-1:0]  tgt_lanes;
	logic              tgt_valid;

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		next_busy  = busy;
		next_count = count;
		next_beats = beats + {{(CNT_W-1){1'b0}}, bus.local_beat_strobe};
		next_len   = len;
		if (req) begin
			next_req = (bus.local_master_phase != PH_ADDR_LOAD);
		end else begin
			next_req = I_START && !busy;
		end
		if (I_START && !busy) begin
			next_busy  = 1'b1;
			next_count = I_ADDR;
			next_beats = CNT_RST;
			next_len   = I_LEN;
		end else if (bus.local_master_phase == PH_BUS_TERM) begin
			next_busy = 1'b0;
		end
		if (bus.local_beat_strobe) begin
			next_count = count + ADDR_STEP;
		end
		next_ready = I_WORD_VALID && next_busy;
		// Address and command share the word lines while requesting
		next_word  = next_req ? I_ADDR : I_WORD;
		next_lanes = next_req ? I_CMD : I_LANES;
		next_gnt   = !bus.req_n;
		// Fast decode: select one cycle after the address phase
		tgt_done = sel && !bus.irdy_n && !bus.trdy_n;
		next_sel = sel;
		if (!sel && !bus.frame_n && frame_q) begin
			next_sel = 1'b1;
		end else if (tgt_done && bus.frame_n) begin
			next_sel = 1'b0;
		end
	end

	// ****************************************************
	// Registers
	// ****************************************************
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			req       <= 1'b0;
			busy      <= 1'b0;
			ready     <= 1'b0;
			word      <= AD_RST;
			lanes     <= CBE_RST;
			len       <= LEN_RST;
			count     <= AD_RST;
			beats     <= CNT_RST;
			gnt       <= 1'b0;
			frame_q   <= 1'b1;
			sel       <= 1'b0;
			tgt_word  <= AD_RST;
			tgt_lanes <= CBE_RST;
			tgt_valid <= 1'b0;
		end else begin
			req       <= next_req;
			busy      <= next_busy;
			ready     <= next_ready;
			word      <= next_word;
			lanes     <= next_lanes;
			len       <= next_len;
			count     <= next_count;
			beats     <= next_beats;
			gnt       <= next_gnt;
			frame_q   <= bus.frame_n;
			sel       <= next_sel;
			tgt_word  <= tgt_done ? bus.ad : tgt_word;
			tgt_lanes <= tgt_done ? bus.cbe_n : tgt_lanes;
			tgt_valid <= tgt_done;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign bus.local_req_32       = req;
	assign bus.local_master_ready = ready;
	assign bus.local_write_word   = word;
	assign bus.local_byte_lanes   = lanes;
	assign bus.burst_len_in       = len;
	assign bus.gnt_n              = !gnt;
	assign bus.devsel_n_o         = !sel;
	assign bus.devsel_oe          = sel;
	assign bus.trdy_n_o           = !(sel && !I_TGT_STALL);
	assign bus.trdy_oe            = sel;
	assign O_NEXT_INDEX = beats + {{(CNT_W-1){1'b0}}, bus.local_beat_strobe};
	assign O_ADDR_COUNT           = count;
	assign O_BUSY                 = busy;
	assign O_TGT_WORD             = tgt_word;
	assign O_TGT_LANES            = tgt_lanes;
	assign O_TGT_VALID            = tgt_valid;
endmodule

// file: verification/pmw_properties.sv
// Concurrent checks on the link between the core end and its partner
`timescale 1ns/1ps
module pmw_properties (
	input  wire logic                       I_CLK_SYS,
	input  wire logic                       I_RST_N,
	input  wire logic                       req_n,
	input  wire logic                       gnt_n,
	input  wire logic                       frame_n,
	input  wire logic                       frame_oe,
	input  wire logic                       irdy_n,
	input  wire logic                       trdy_n,
	input  wire logic [pmw_pkg::AD_W-1:0]   ad,
	input  wire logic                       ad_oe,
	input  wire logic [pmw_pkg::CBE_W-1:0]  cbe_n,
	input  wire logic                       local_req_32,
	input  wire logic                       local_grant,
	input  wire pmw_pkg::pmw_phase_t        local_master_phase,
	input  wire pmw_pkg::pmw_cause_t        end_cause,
	input  wire logic [pmw_pkg::CNT_W-1:0]  remaining_beats,
	input  wire logic [pmw_pkg::LEN_W-1:0]  burst_len_in,
	input  wire logic [pmw_pkg::AD_W-1:0]   local_write_word,
	input  wire logic [pmw_pkg::CBE_W-1:0]  local_byte_lanes,
	input  wire logic                       local_master_ready,
	input  wire logic                       local_beat_strobe
);
	import pmw_pkg::*;

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	a_addr_load_cause: assert property (
		local_master_phase == PH_ADDR_LOAD && $past(local_master_phase) == PH_IDLE
		|-> $past(local_req_32) && !$past(gnt_n))
		else $error("address loading without request and grant");
	a_req_drop: assert property (
		local_master_phase == PH_ADDR_LOAD |=> !local_req_32)
		else $error("local request kept after address loading");
	a_frame_start: assert property (
		local_master_phase == PH_ADDR_LOAD && !gnt_n |=> !frame_n
		&& local_master_phase == PH_BUS_TXN && ad == $past(local_write_word)
		&& cbe_n == $past(local_byte_lanes))
		else $error("address phase missing or wrong");
	a_len_load: assert property (
		local_master_phase == PH_ADDR_LOAD && !gnt_n
		|=> remaining_beats == {1'b0, $past(burst_len_in)})
		else $error("beat count not loaded from length");
	a_strobe_cause: assert property (
		local_beat_strobe |-> $past(local_master_ready))
		else $error("strobe without prior ready");
	a_req_release: assert property (
		!frame_n && !local_req_32 |=> req_n)
		else $error("bus request kept after frame");
	a_grant_follow: assert property (
		gnt_n |=> !local_grant)
		else $error("local grant outlives bus grant");
	a_phase_hold: assert property (
		!irdy_n && trdy_n |=> $stable(ad) && $stable(cbe_n) && $stable(frame_n))
		else $error("bus lines changed before completion");
	a_count_down: assert property (
		!irdy_n && !trdy_n |=> remaining_beats == $past(remaining_beats) - CNT_ONE)
		else $error("beat count not decremented");
	a_last_frame: assert property (
		frame_oe && frame_n && !irdy_n |-> remaining_beats == CNT_ONE)
		else $error("frame released before last phase");
	a_normal_end: assert property (
		!irdy_n && !trdy_n && frame_n |=> local_master_phase == PH_BUS_TERM
		&& end_cause == END_NORMAL && !frame_oe && !ad_oe)
		else $error("no normal termination after last phase");

	// ****************************************************
	// Coverage
	// ****************************************************
	cover property (local_master_phase == PH_BUS_TERM);
	cover property (!frame_n && irdy_n && remaining_beats != CNT_RST);
	cover property (!irdy_n && trdy_n);
	cover property (local_beat_strobe && !irdy_n && trdy_n);
endmodule

// file: verification/tb_pci_master_burst_write.sv
// Self-checking bench joining the core end to its partner end
`timescale 1ns/1ps
module tb_pci_master_burst_write;
	import pmw_pkg::*;

	// ****************************************************
	// Signals
	// ****************************************************
	localparam int LIMIT = 3000;
	logic             clk_sys   = 1'b0;
	logic             rst_n     = 1'b0;
	logic             start     = 1'b0;
	logic [AD_W-1:0]  addr      = AD_RST;
	logic [CBE_W-1:0] cmd       = 4'h7;
	logic [LEN_W-1:0] len       = LEN_RST;
	logic [AD_W-1:0]  word      = AD_RST;
	logic [CBE_W-1:0] lanes     = CBE_RST;
	logic             wvalid    = 1'b0;
	logic             stall     = 1'b0;
	logic             vmode     = 1'b0;
	logic             smode     = 1'b0;
	logic [CNT_W-1:0] got       = CNT_RST;
	logic [CNT_W-1:0] strobes   = CNT_RST;
	logic [CNT_W-1:0] next_idx;
	logic [AD_W-1:0]  addr_cnt;
	logic [AD_W-1:0]  tgt_word;
	logic [CBE_W-1:0] tgt_lanes;
	logic             busy;
	logic             tgt_valid;
	logic             done;
	int               failures     = 0;
	int               total_checks = 0;
	int               cyc          = 0;

	pmw_if ifc ();
	pmw_core pmw_core_inst (.I_CLK_SYS(clk_sys), .I_RST_N(rst_n),
		.bus(ifc.core), .O_DONE(done));
	pmw_partner pmw_partner_inst (.I_CLK_SYS(clk_sys), .I_RST_N(rst_n),
		.bus(ifc.partner), .I_START(start), .I_ADDR(addr), .I_CMD(cmd),
		.I_LEN(len), .I_WORD(word), .I_LANES(lanes), .I_WORD_VALID(wvalid),
		.I_TGT_STALL(stall), .O_NEXT_INDEX(next_idx), .O_ADDR_COUNT(addr_cnt),
		.O_BUSY(busy), .O_TGT_WORD(tgt_word), .O_TGT_LANES(tgt_lanes),
		.O_TGT_VALID(tgt_valid));
	pmw_properties pmw_properties_inst (.I_CLK_SYS(clk_sys), .I_RST_N(rst_n),
		.req_n(ifc.req_n), .gnt_n(ifc.gnt_n), .frame_n(ifc.frame_n),
		.frame_oe(ifc.frame_oe), .irdy_n(ifc.irdy_n), .trdy_n(ifc.trdy_n),
		.ad(ifc.ad), .ad_oe(ifc.ad_oe), .cbe_n(ifc.cbe_n),
		.local_req_32(ifc.local_req_32), .local_grant(ifc.local_grant),
		.local_master_phase(ifc.local_master_phase),
		.end_cause(ifc.end_cause), .remaining_beats(ifc.remaining_beats),
		.burst_len_in(ifc.burst_len_in),
		.local_write_word(ifc.local_write_word),
		.local_byte_lanes(ifc.local_byte_lanes),
		.local_master_ready(ifc.local_master_ready),
		.local_beat_strobe(ifc.local_beat_strobe));

	// ****************************************************
	// Helpers
	// ****************************************************
	// Index folded into the word so a dropped or repeated beat shows
	function automatic logic [AD_W-1:0] word_of(input logic [CNT_W-1:0] i);
		word_of = {16'hC3A0, 3'h0, i};
	endfunction

	function automatic logic [CBE_W-1:0] lanes_of(input logic [CNT_W-1:0] i);
		lanes_of = i[3:0] ^ 4'h9;
	endfunction

	task automatic check_val(input logic [AD_W-1:0] g, input logic [AD_W-1:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************************
	// Drivers and monitors
	// ****************************************************
	always #4 clk_sys = ~clk_sys;

	// Local words follow the partner index; stalls come in patterns
	always @(negedge clk_sys) begin
		cyc <= cyc + 1;
		word <= word_of(next_idx);
		lanes <= lanes_of(next_idx);
		wvalid <= !vmode || cyc[1];
		stall <= smode && cyc[0];
		if (ifc.local_beat_strobe === 1'b1) begin
			strobes <= strobes + CNT_ONE;
		end
		if (tgt_valid === 1'b1) begin
			check_val(tgt_word, word_of(got));
			check_val({28'h0, tgt_lanes}, {28'h0, lanes_of(got)});
			got <= got + CNT_ONE;
		end
		if (cyc == LIMIT) begin
			failures++;
			conclude();
		end
	end

	task automatic burst(input logic [LEN_W-1:0] n, input logic v,
		input logic s);
		int k;
		@(negedge clk_sys);
		vmode = v;
		smode = s;
		got = CNT_RST;
		strobes = CNT_RST;
		len = n;
		addr = {8'h80, 12'h000, n};
		cmd = cmd ^ 4'h1;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		for (k = 0; k < 40 && ifc.frame_n !== 1'b0; k++) @(negedge clk_sys);
		check_val(ifc.ad, addr);
		check_val({28'h0, ifc.cbe_n}, {28'h0, cmd});
		check_val({31'h0, ifc.local_grant}, 32'h0000_0001);
		check_val({31'h0, ifc.req_n}, AD_RST);
		check_val({19'h0, ifc.remaining_beats}, {20'h0, n});
		check_val({28'h0, ifc.local_master_phase}, {28'h0, PH_BUS_TXN});
		for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge clk_sys);
		check_val({29'h0, ifc.end_cause}, {29'h0, END_NORMAL});
		check_val({28'h0, ifc.local_master_phase}, {28'h0, PH_BUS_TERM});
		check_val({19'h0, ifc.remaining_beats}, AD_RST);
		check_val({31'h0, ifc.frame_n}, 32'h0000_0001);
		for (k = 0; k < 20 && (busy !== 1'b0
			|| ifc.local_master_phase !== PH_IDLE); k++) @(negedge clk_sys);
		check_val({19'h0, got}, {20'h0, n});
		check_val({19'h0, strobes}, {20'h0, n});
		check_val(addr_cnt, addr + {18'h0, n, 2'h0});
		check_val({31'h0, ifc.local_grant}, AD_RST);
		check_val({31'h0, ifc.req_n}, 32'h0000_0001);
	endtask

	// ****************************************************
	// Sequence
	// ****************************************************
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		burst(12'h001, 1'b0, 1'b0);
		burst(12'h004, 1'b0, 1'b0);
		burst(12'h005, 1'b1, 1'b0);
		burst(12'h003, 1'b0, 1'b1);
		burst(12'h006, 1'b1, 1'b1);
		conclude();
	end
endmodule
